// [hw/mbf_pkg.sv]
// constants for the modbus slave function handler
package mbf_pkg;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_ERR_BIT = 8'h80;
  localparam logic [7:0] EX_ILL_FUNC = 8'h01;
  localparam logic [7:0] EX_ILL_ADDR = 8'h02;
  localparam logic [7:0] EX_ILL_VALUE = 8'h03;
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX = 16'h007d;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] COIL_MAX_ADDR = 16'h0018;
  localparam int COIL_COUNT = 25;
  localparam logic [15:0] SUB_QUERY = 16'h0000;
  localparam logic [15:0] SUB_RESTART = 16'h0001;
  localparam logic [15:0] SUB_DIAG_REG = 16'h0002;
  localparam logic [15:0] SUB_DELIM = 16'h0003;
  localparam logic [15:0] SUB_LISTEN = 16'h0004;
  localparam logic [15:0] SUB_CLR_CNT = 16'h000a;
  localparam logic [15:0] SUB_LAST_CNT = 16'h0012;
  localparam logic [15:0] SUB_CLR_OVR = 16'h0014;
  localparam logic [15:0] LOG_CLEAR_VAL = 16'hff00;
  localparam logic [7:0] DELIM_RESET = 8'h0a;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_COILS = 8'h08;
  localparam logic [7:0] APB_DELIM = 8'h0c;
  localparam logic [7:0] APB_OVR_CNT = 8'h10;
  localparam logic [7:0] APB_MSG_CNT = 8'h14;
  typedef enum logic [2:0] {MBF_IDLE, MBF_EXEC, MBF_RESP, MBF_REGWAIT, MBF_RESTART} mbf_state_t;
endpackage

// [hw/mbf_handler.sv]
// modbus slave pdu function handler with apb status and control
// Function
// - read-input request: code 04, start address, quantity 0001..007d from master.
// - read-input reply: code 04, byte count twice quantity, two bytes per register.
// - errors reply function code plus 80 and a one-byte exception code.
// - failed diagnostics reply 88 with exception 01, 03 or 04 only.
// - write-coil value ff00 sets coil, 0000 clears, other values change nothing.
// - coil addresses are zero-based, two bytes wide.
// - holding register addresses are zero-based.
// - write-coil reply echoes address and value after the coil is updated.
// - write-register reply echoes address and value after the register is written.
// - diagnostics reply echoes function and sub-function codes.
// - diagnostics never touch coils or registers; some clear counters.
// - supported sub-functions are 00-04, 0a-12 and 14.
// - sub-function 00 returns request data unchanged.
// - sub-function 01 restarts port, clears counters, runs self tests first.
// - restart in listen-only mode sends no reply but restarts, and leaves mode only if the self test passes.
// - restart outside listen-only mode replies before restarting.
// - restart data ff00 also clears event log; 0000 keeps it.
// - sub-function 02 returns the diagnostic register, always zero.
// - sub-function 03 sets ascii delimiter from high data byte; restart restores lf.
// - sub-function 04 enters listen-only mode without reply.
// - listen-only mode disables talk, takes no action except restart and sends no reply.
// - sub-function 0a clears all counters and diagnostic register, echoes data.
// - coils 0..24 map onto the 25-bit coils output; higher addresses get exception 02.
// - sub-function 14 clears overrun counter and flag, echoes data.
`timescale 1ns/1ps
module mbf_handler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request pdu from frame decoder
  input wire logic req_valid,
  input wire logic req_bcast,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  output logic req_ready,
  // response header
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_func,
  output logic [15:0] rsp_word0,
  output logic [15:0] rsp_word1,
  output logic rsp_short,
  output logic rsp_exception,
  // input register read port
  output logic ireg_rd,
  output logic [15:0] ireg_start,
  output logic [7:0] ireg_count,
  // holding register write port
  output logic hreg_wr,
  output logic [15:0] hreg_addr,
  output logic [15:0] hreg_wdata,
  input wire logic hreg_done,
  // serial port control
  input wire logic char_overrun,
  output logic port_restart,
  output logic log_clear,
  output logic talk_enable,
  output logic [7:0] ascii_delim,
  output logic [mbf_pkg::COIL_COUNT-1:0] coils
);
  localparam int COIL_COUNT = mbf_pkg::COIL_COUNT;

  mbf_pkg::mbf_state_t state;
  logic [7:0] func;
  logic [15:0] addr;
  logic [15:0] data;
  logic bcast;
  logic listen_only;
  logic restart_log;
  logic selftest_ok;
  logic [15:0] ovr_cnt;
  logic [15:0] msg_cnt;
  logic ovr_flag;
  logic [7:0] ex_code;
  logic do_coil;
  logic do_reg;
  logic clr_cnt;
  logic clr_ovr;
  logic set_delim;
  logic go_listen;
  logic apb_wr;

  // supported diagnostic sub-functions
  function automatic logic sub_ok(input logic [15:0] s);
    sub_ok = (s <= mbf_pkg::SUB_LISTEN) ||
             ((s >= mbf_pkg::SUB_CLR_CNT) && (s <= mbf_pkg::SUB_LAST_CNT)) ||
             (s == mbf_pkg::SUB_CLR_OVR);
  endfunction

  // exception code for the latched request, zero when legal
  always_comb begin
    ex_code = 8'h00;
    case (func)
      mbf_pkg::FC_RD_INPUT: begin
        if (data < mbf_pkg::QTY_MIN || data > mbf_pkg::QTY_MAX) begin
          ex_code = mbf_pkg::EX_ILL_VALUE;
        end
      end
      mbf_pkg::FC_WR_COIL: begin
        if (data != mbf_pkg::COIL_ON && data != mbf_pkg::COIL_OFF) begin
          ex_code = mbf_pkg::EX_ILL_VALUE;
        end else if (addr > mbf_pkg::COIL_MAX_ADDR) begin
          ex_code = mbf_pkg::EX_ILL_ADDR;
        end
      end
      mbf_pkg::FC_WR_REG: ex_code = 8'h00;
      mbf_pkg::FC_DIAG: begin
        if (!sub_ok(addr)) begin
          ex_code = mbf_pkg::EX_ILL_FUNC;
        end
      end
      default: ex_code = mbf_pkg::EX_ILL_FUNC;
    endcase
  end

  // actions taken in the execute cycle, counter clears also in the restart cycle; diagnostics touch no user data
  assign do_coil = (state == mbf_pkg::MBF_EXEC) && func == mbf_pkg::FC_WR_COIL && ex_code == 8'h00;
  assign do_reg = (state == mbf_pkg::MBF_EXEC) && func == mbf_pkg::FC_WR_REG;
  assign clr_cnt = (state == mbf_pkg::MBF_RESTART) ||
                   ((state == mbf_pkg::MBF_EXEC) && func == mbf_pkg::FC_DIAG && addr == mbf_pkg::SUB_CLR_CNT);
  assign clr_ovr = clr_cnt ||
                   ((state == mbf_pkg::MBF_EXEC) && func == mbf_pkg::FC_DIAG && addr == mbf_pkg::SUB_CLR_OVR);
  assign set_delim = (state == mbf_pkg::MBF_EXEC) && func == mbf_pkg::FC_DIAG && addr == mbf_pkg::SUB_DELIM;
  assign go_listen = (state == mbf_pkg::MBF_EXEC) && func == mbf_pkg::FC_DIAG && addr == mbf_pkg::SUB_LISTEN;

  assign req_ready = (state == mbf_pkg::MBF_IDLE);

  // request sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mbf_pkg::MBF_IDLE;
      func <= 8'h00;
      addr <= 16'h0000;
      data <= 16'h0000;
      bcast <= 1'b0;
      restart_log <= 1'b0;
    end else begin
      case (state)
        mbf_pkg::MBF_IDLE: begin
          if (req_valid) begin
            func <= req_func;
            addr <= req_addr;
            data <= req_data;
            bcast <= req_bcast;
            // listen-only: only restart is processed, everything else dropped
            if (!listen_only || (req_func == mbf_pkg::FC_DIAG && req_addr == mbf_pkg::SUB_RESTART)) begin
              state <= mbf_pkg::MBF_EXEC;
            end
          end
        end
        mbf_pkg::MBF_EXEC: begin
          restart_log <= (data == mbf_pkg::LOG_CLEAR_VAL);
          if (do_reg) begin
            state <= mbf_pkg::MBF_REGWAIT;
          end else if (func == mbf_pkg::FC_DIAG && ex_code == 8'h00 && addr == mbf_pkg::SUB_RESTART) begin
            state <= (listen_only || bcast) ? mbf_pkg::MBF_RESTART : mbf_pkg::MBF_RESP;
          end else if (go_listen || bcast) begin
            state <= mbf_pkg::MBF_IDLE;
          end else begin
            state <= mbf_pkg::MBF_RESP;
          end
        end
        mbf_pkg::MBF_REGWAIT: begin
          if (hreg_done) begin
            state <= bcast ? mbf_pkg::MBF_IDLE : mbf_pkg::MBF_RESP;
          end
        end
        mbf_pkg::MBF_RESP: begin
          if (rsp_ready) begin
            // reply goes out before the restart takes effect
            if (func == mbf_pkg::FC_DIAG && addr == mbf_pkg::SUB_RESTART && ex_code == 8'h00) begin
              state <= mbf_pkg::MBF_RESTART;
            end else begin
              state <= mbf_pkg::MBF_IDLE;
            end
          end
        end
        mbf_pkg::MBF_RESTART: state <= mbf_pkg::MBF_IDLE;
        default: state <= mbf_pkg::MBF_IDLE;
      endcase
    end
  end

  // response fields, held until accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_func <= 8'h00;
      rsp_word0 <= 16'h0000;
      rsp_word1 <= 16'h0000;
      rsp_short <= 1'b0;
      rsp_exception <= 1'b0;
    end else if (state == mbf_pkg::MBF_EXEC) begin
      rsp_exception <= (ex_code != 8'h00);
      if (ex_code != 8'h00) begin
        rsp_func <= func | mbf_pkg::FC_ERR_BIT;
        rsp_word0 <= {8'h00, ex_code};
        rsp_word1 <= 16'h0000;
        rsp_short <= 1'b1;
      end else if (func == mbf_pkg::FC_RD_INPUT) begin
        rsp_func <= func;
        rsp_word0 <= {8'h00, data[6:0], 1'b0};
        rsp_word1 <= addr;
        rsp_short <= 1'b1;
      end else begin
        rsp_func <= func;
        rsp_word0 <= addr;
        rsp_word1 <= (func == mbf_pkg::FC_DIAG && addr == mbf_pkg::SUB_DIAG_REG) ? 16'h0000 : data;
        rsp_short <= 1'b0;
      end
    end
  end

  assign rsp_valid = (state == mbf_pkg::MBF_RESP);

  // input register read request alongside the reply header
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ireg_rd <= 1'b0;
      ireg_start <= 16'h0000;
      ireg_count <= 8'h00;
    end else begin
      ireg_rd <= (state == mbf_pkg::MBF_EXEC) && func == mbf_pkg::FC_RD_INPUT && ex_code == 8'h00 && !bcast;
      if (state == mbf_pkg::MBF_EXEC) begin
        ireg_start <= addr;
        ireg_count <= data[7:0];
      end
    end
  end

  // holding register write strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hreg_wr <= 1'b0;
      hreg_addr <= 16'h0000;
      hreg_wdata <= 16'h0000;
    end else begin
      hreg_wr <= do_reg;
      if (do_reg) begin
        hreg_addr <= addr;
        hreg_wdata <= data;
      end
    end
  end

  // coil outputs, zero-based addressing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coils <= '0;
    end else if (do_coil) begin
      coils[addr[4:0]] <= (data == mbf_pkg::COIL_ON);
    end else if (apb_wr && paddr == mbf_pkg::APB_COILS) begin
      coils <= pwdata[COIL_COUNT-1:0];
    end
  end

  // listen-only mode and delimiter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      listen_only <= 1'b0;
      ascii_delim <= mbf_pkg::DELIM_RESET;
    end else if (state == mbf_pkg::MBF_RESTART) begin
      listen_only <= !selftest_ok;
      ascii_delim <= mbf_pkg::DELIM_RESET;
    end else if (go_listen) begin
      listen_only <= 1'b1;
    end else if (set_delim) begin
      ascii_delim <= data[15:8];
    end
  end

  assign talk_enable = !listen_only;
  assign port_restart = (state == mbf_pkg::MBF_RESTART);
  assign log_clear = (state == mbf_pkg::MBF_RESTART) && restart_log;

  // counters; an overrun in the clearing cycle still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_cnt <= mbf_pkg::CNT_RESET;
      ovr_flag <= 1'b0;
      msg_cnt <= mbf_pkg::CNT_RESET;
    end else begin
      if (char_overrun) begin
        ovr_cnt <= clr_ovr ? 16'h0001 : ovr_cnt + 16'h0001;
        ovr_flag <= 1'b1;
      end else if (clr_ovr) begin
        ovr_cnt <= mbf_pkg::CNT_RESET;
        ovr_flag <= 1'b0;
      end
      if (req_valid && req_ready) begin
        msg_cnt <= clr_cnt ? 16'h0001 : msg_cnt + 16'h0001;
      end else if (clr_cnt) begin
        msg_cnt <= mbf_pkg::CNT_RESET;
      end
    end
  end

  // self-test result set by software, defaults to pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selftest_ok <= 1'b1;
    end else if (apb_wr && paddr == mbf_pkg::APB_CTRL) begin
      selftest_ok <= pwdata[0];
    end
  end

  // apb slave, zero wait states
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        mbf_pkg::APB_CTRL: prdata <= {31'h0, selftest_ok};
        mbf_pkg::APB_STATUS: prdata <= {29'h0, ovr_flag, listen_only, state != mbf_pkg::MBF_IDLE};
        mbf_pkg::APB_COILS: prdata <= {7'h0, coils};
        mbf_pkg::APB_DELIM: prdata <= {24'h0, ascii_delim};
        mbf_pkg::APB_OVR_CNT: prdata <= {16'h0, ovr_cnt};
        mbf_pkg::APB_MSG_CNT: prdata <= {16'h0, msg_cnt};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// [sim/mbf_handler_checker.sv]
// assertion checker for the modbus function handler
`timescale 1ns/1ps
module mbf_handler_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // reply and port control
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_func,
  input wire logic [15:0] rsp_word0,
  input wire logic [15:0] rsp_word1,
  input wire logic rsp_short,
  input wire logic rsp_exception,
  input wire logic port_restart,
  input wire logic log_clear,
  input wire logic talk_enable,
  input wire logic [7:0] ascii_delim,
  input wire logic [mbf_pkg::COIL_COUNT-1:0] coils
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable({rsp_func, rsp_word0, rsp_word1}))
    else $error("reply changed before taken");
  exc_form_a: assert property (rsp_valid && rsp_exception |-> rsp_func[7] && rsp_short && rsp_word0 inside {[1:4]})
    else $error("bad exception reply");
  diag_exc_a: assert property (rsp_valid && rsp_func == 8'h88 |-> rsp_word0[7:0] != 8'h02)
    else $error("diagnostics used code 02");
  rd_count_a: assert property (rsp_valid && rsp_func == 8'h04 |-> rsp_short && rsp_word0 inside {[2:250]} && !rsp_word0[0])
    else $error("bad read byte count");
  diag_zero_a: assert property (rsp_valid && rsp_func == 8'h08 && rsp_word0 == 16'h0002 |-> rsp_word1 == 16'h0000)
    else $error("diagnostic register not zero");
  coil_first_a: assert property ($rose(rsp_valid) && rsp_func == 8'h05 && rsp_word1 == 16'hff00 && rsp_word0 < 16'h0019
    |-> coils[rsp_word0[4:0]])
    else $error("coil echo before update");
  restart_lf_a: assert property (port_restart |=> ascii_delim == 8'h0a)
    else $error("delimiter not restored");
  log_clr_a: assert property (log_clear |-> port_restart)
    else $error("log clear without restart");
  quiet_listen_a: assert property (!talk_enable |-> !rsp_valid)
    else $error("reply in listen-only");
  reply_first_a: assert property (port_restart |-> !rsp_valid)
    else $error("restart while reply pending");
endmodule
bind mbf_handler mbf_handler_checker u_chk (.pclk, .presetn, .rsp_valid, .rsp_ready, .rsp_func, .rsp_word0,
  .rsp_word1, .rsp_short, .rsp_exception, .port_restart, .log_clear, .talk_enable, .ascii_delim, .coils);

// [sim/mbf_master.sv]
// serial-line master model issuing request pdus and taking replies
`timescale 1ns/1ps
module mbf_master (
  // clock
  input wire logic pclk,
  // request
  output logic req_valid,
  output logic req_bcast,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_data,
  input wire logic req_ready,
  // reply
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [7:0] rsp_func,
  input wire logic [15:0] rsp_word0,
  input wire logic [15:0] rsp_word1
);
  initial begin
    {req_valid, req_bcast, req_func, req_addr, req_data, rsp_ready} = '0;
  end
  // stall delays the reply acceptance; no reply leaves got low
  task xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic b, input int stall,
      output logic got, output logic tmo, output logic [7:0] rf, output logic [15:0] r0, output logic [15:0] r1);
    int i;
    got = 1'b0;
    tmo = 1'b1;
    @(posedge pclk);
    {req_valid, req_bcast, req_func, req_addr, req_data} <= {1'b1, b, f, a, d};
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (req_ready) begin
        tmo = 1'b0;
        break;
      end
    end
    // released lines must not keep the last value
    {req_valid, req_bcast, req_func, req_addr, req_data} <= {1'b0, ~b, ~f, ~a, ~d};
    for (i = 0; i < 24; i++) begin
      if (i == stall) rsp_ready <= 1'b1;
      @(posedge pclk);
      if (rsp_valid && rsp_ready) begin
        {got, rf, r0, r1} = {1'b1, rsp_func, rsp_word0, rsp_word1};
        break;
      end
    end
    rsp_ready <= 1'b0;
  endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the modbus function handler
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_bcast, req_ready;
  logic rsp_valid, rsp_ready, rsp_short, rsp_exception, ireg_rd, hreg_wr, hreg_done, char_overrun;
  logic port_restart, log_clear, talk_enable, got, rs_seen, lc_seen, ir_seen;
  logic [7:0] paddr, req_func, rsp_func, ireg_count, ascii_delim, rf;
  logic [15:0] req_addr, req_data, rsp_word0, rsp_word1, ireg_start, hreg_addr, hreg_wdata, r0, r1;
  logic [31:0] pwdata, prdata, v;
  logic [2:0] hd;
  logic [mbf_pkg::COIL_COUNT-1:0] coils;
  logic [15:0] bad [8] = '{16'h5, 16'h6, 16'h7, 16'h8, 16'h9, 16'h13, 16'h15, 16'h21};
  int fail_count, tests_run, st, i;
  mbf_handler dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req_bcast, .req_func, .req_addr, .req_data, .req_ready, .rsp_valid, .rsp_ready, .rsp_func,
    .rsp_word0, .rsp_word1, .rsp_short, .rsp_exception, .ireg_rd, .ireg_start, .ireg_count, .hreg_wr,
    .hreg_addr, .hreg_wdata, .hreg_done, .char_overrun, .port_restart, .log_clear, .talk_enable,
    .ascii_delim, .coils);
  mbf_master u_mst (.pclk, .req_valid, .req_bcast, .req_func, .req_addr, .req_data, .req_ready, .rsp_valid,
    .rsp_ready, .rsp_func, .rsp_word0, .rsp_word1);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // slow register file: write completes four cycles late
  always @(posedge pclk) begin
    hd <= {hd[1:0], hreg_wr};
    hreg_done <= hd[2];
    if (port_restart) rs_seen <= 1'b1;
    if (log_clear) lc_seen <= 1'b1;
  end
  // read strobe lasts one cycle, so catch it between edges
  always @(negedge pclk) begin
    if (ireg_rd) ir_seen <= 1'b1;
  end
  task finish_test;
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [47:0] g, input logic [47:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready) break;
    end
    if (k == 20) begin
      fail_count++;
      finish_test();
    end
    v = prdata;
    chk(pslverr, 1'b0);
    {psel, penable} <= 2'b00;
  endtask
  task rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic b);
    logic tmo;
    u_mst.xfer(f, a, d, b, st, got, tmo, rf, r0, r1);
    if (tmo) begin
      fail_count++;
      finish_test();
    end
  endtask
  task echo(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    rq(f, a, d, 1'b0);
    chk({got, rf, r0, r1}, {1'b1, f, a, d});
  endtask
  task exc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    rq(f, a, d, 1'b0);
    chk({got, rf, r0, r1}, {1'b1, f | 8'h80, 8'h00, c, 16'h0000});
  endtask
  task ovr;
    @(posedge pclk);
    char_overrun <= 1'b1;
    @(posedge pclk);
    char_overrun <= 1'b0;
  endtask
  task t_coil;
    apb(1'b1, 8'h08, 32'h1);
    @(posedge pclk);
    chk(coils, 25'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(v, 32'h0);
    echo(8'h05, 16'h0003, 16'hff00);
    chk(coils, 25'h9);
    echo(8'h05, 16'h0018, 16'hff00);
    exc(8'h05, 16'h0019, 16'hff00, 8'h02);
    exc(8'h05, 16'h0003, 16'h1234, 8'h03);
    echo(8'h05, 16'h0000, 16'h0000);
    rq(8'h05, 16'h0005, 16'hff00, 1'b1);
    chk({got, coils}, {1'b0, 25'h1000028});
  endtask
  task t_reg;
    st = 3;
    echo(8'h06, 16'h0000, 16'ha5a5);
    chk({hreg_addr, hreg_wdata}, {16'h0000, 16'ha5a5});
    st = 0;
  endtask
  task t_read;
    ir_seen = 1'b0;
    rq(8'h04, 16'h0010, 16'h0001, 1'b0);
    chk({got, rf, r0, r1, ir_seen}, {1'b1, 8'h04, 16'h0002, 16'h0010, 1'b1});
    rq(8'h04, 16'h0010, 16'h007d, 1'b0);
    chk({got, rf, r0}, {1'b1, 8'h04, 16'h00fa});
    chk({ireg_start, ireg_count}, {16'h0010, 8'h7d});
    ir_seen = 1'b0;
    exc(8'h04, 16'h0010, 16'h0000, 8'h03);
    exc(8'h04, 16'h0010, 16'h007e, 8'h03);
    chk(ir_seen, 1'b0);
  endtask
  task t_diag;
    echo(8'h08, 16'h0000, 16'h1234);
    rq(8'h08, 16'h0002, 16'h1234, 1'b0);
    chk({got, rf, r0, r1}, {1'b1, 8'h08, 16'h0002, 16'h0000});
    echo(8'h08, 16'h0003, 16'h3b00);
    chk(ascii_delim, 8'h3b);
    foreach (bad[j]) exc(8'h08, bad[j], 16'h0000, 8'h01);
    for (i = 11; i <= 18; i++) begin
      rq(8'h08, i[15:0], 16'h0000, 1'b0);
      chk({got, rf, r0}, {1'b1, 8'h08, i[15:0]});
      chk(coils, 25'h1000028);
    end
    ovr();
    apb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h1);
    echo(8'h08, 16'h0014, 16'h0000);
    apb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h0);
    ovr();
    echo(8'h08, 16'h000a, 16'h0000);
    apb(1'b0, 8'h10, 32'h0);
    chk(v, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(v, 32'h0);
  endtask
  task t_listen;
    rq(8'h08, 16'h0004, 16'h0000, 1'b0);
    chk({got, talk_enable}, 2'b00);
    rq(8'h05, 16'h0007, 16'hff00, 1'b0);
    chk({got, coils[7]}, 2'b00);
    {rs_seen, lc_seen} = 2'b00;
    rq(8'h08, 16'h0001, 16'hff00, 1'b0);
    chk({got, rs_seen, lc_seen, talk_enable, ascii_delim}, {4'b0111, 8'h0a});
    apb(1'b1, 8'h00, 32'h0);
    {rs_seen, lc_seen} = 2'b00;
    echo(8'h08, 16'h0001, 16'h0000);
    for (i = 0; i < 10 && !rs_seen; i++) @(posedge pclk);
    chk({rs_seen, lc_seen, talk_enable}, 3'b100);
    apb(1'b1, 8'h00, 32'h1);
    rq(8'h08, 16'h0001, 16'h0000, 1'b0);
    chk({got, talk_enable}, 2'b01);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, char_overrun, hreg_done, hd, rs_seen, lc_seen, ir_seen} = '0;
    {fail_count, tests_run, st} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_coil();
    t_reg();
    t_read();
    t_diag();
    t_listen();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    finish_test();
  end
endmodule
